// >>> hdl/lpms_pkg.sv
// constants and types shared by the low power mode sequencer
package lpms_pkg;

    // ------------------------------------------------------------
    // bus and register map
    // ------------------------------------------------------------
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    localparam logic [11:0] OFF_SYS_CTRL = 12'h000;
    localparam logic [11:0] OFF_RST_CAUSE = 12'h004;
    localparam logic [11:0] OFF_CLK_SETUP = 12'h008;
    localparam logic [11:0] OFF_TRIM1 = 12'h00C;
    localparam logic [11:0] OFF_TRIM2 = 12'h010;
    localparam logic [11:0] OFF_MODE = 12'h014;
    localparam logic [11:0] OFF_IRQ_ST = 12'h018;
    localparam logic [11:0] OFF_IRQ_MASK = 12'h01C;
    localparam int RAM_SEL_BIT = 11;

    // ------------------------------------------------------------
    // field positions and reset values
    // ------------------------------------------------------------
    localparam int SC_SLEEP_ALLOW = 7;
    localparam int SC_PCFG_ALLOW = 6;
    localparam int SC_BUSERR_EN = 5;
    localparam int SC_WD_EN = 4;
    localparam logic [7:0] SC_MASK = 8'hF0;
    localparam logic [7:0] SC_STICKY = 8'h10;
    localparam int RC_SLEEP_REQ = 7;
    localparam int RC_SLEPT = 6;
    localparam int RC_BUSERR = 5;
    localparam int RC_WD = 4;
    localparam int RC_PORTA = 3;
    localparam logic [7:0] RC_MASK = 8'h78;
    localparam int CS_EXT_CLK = 7;
    localparam int CS_RC_BIAS = 6;
    localparam int CS_XTAL_EN = 5;
    localparam int CS_RC_EN = 4;
    localparam int CS_DIV_LO = 0;
    localparam int CS_DIV_W = 3;
    localparam logic [7:0] CS_MASK = 8'hF7;
    localparam logic [7:0] CLK_SETUP_RST = 8'h10;
    localparam logic [2:0] CPU_DIV_RST = 3'h0;
    localparam logic [7:0] TRIM_RST = 8'h00;
    localparam logic [15:0] CPU_BOOT_ADDR = 16'h0000;
    localparam int RAM_BYTES = 512;
    localparam int RAM_AW = 9;

    // ------------------------------------------------------------
    // interrupt status bits
    // ------------------------------------------------------------
    localparam int IRQ_W = 4;
    localparam int IRQ_STBY_WAKE = 0;
    localparam int IRQ_PORTA = 1;
    localparam int IRQ_WD = 2;
    localparam int IRQ_BUSERR = 3;

    typedef enum logic [1:0] {MODE_ACTIVE, MODE_STANDBY, MODE_SLEEP} lpms_mode_t;

endpackage

// >>> hdl/lpms_ram.sv
// data ram, byte wide, no reset on the array
`timescale 1ns/1ps
`default_nettype none
module lpms_ram
    import lpms_pkg::*;
#(
    parameter int DEPTH = RAM_BYTES,
    parameter int AW = RAM_AW
)
(
    input wire logic pclk,
    input wire logic we,
    input wire logic [AW-1:0] addr,
    input wire logic [7:0] wdata,
    output logic [7:0] rdata
);
    logic [7:0] mem [DEPTH];

    // contents undefined until software writes them
    always_ff @(posedge pclk)
    begin
        if (we)
        begin
            mem[addr] <= wdata;
        end
        rdata <= mem[addr];
    end
endmodule
`default_nettype wire

// >>> hdl/lpms_rst_if.sv
// reset request and distributed reset signals between core and generator
`timescale 1ns/1ps
`default_nettype none
interface lpms_rst_if;
    logic cold;
    logic other;
    logic pcfg_allow;
    logic in_sleep;
    logic global_n;
    logic pconf_n;
    logic sleep_n;
    logic cold_n;
    modport core (output cold, output other, output pcfg_allow, output in_sleep,
        input global_n, input pconf_n, input sleep_n, input cold_n);
    modport gen (input cold, input other, input pcfg_allow, input in_sleep,
        output global_n, output pconf_n, output sleep_n, output cold_n);
endinterface
`default_nettype wire

// >>> hdl/lpms_rstgen.sv
// generator of the cold, global, port-config and sleep resets
`timescale 1ns/1ps
`default_nettype none
module lpms_rstgen
    import lpms_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    lpms_rst_if.gen rif
);
    typedef struct packed {
        logic global_n;
        logic pconf_n;
        logic sleep_n;
        logic cold_n;
    } lpms_rg_t;

    lpms_rg_t s;
    lpms_rg_t n;

    always_comb
    begin
        n.cold_n = !rif.cold;
        n.global_n = !(rif.cold || rif.other);
        n.pconf_n = !(rif.cold || (rif.other && rif.pcfg_allow));
        n.sleep_n = !(rif.cold || rif.in_sleep);
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            s <= '0;
        end
        else
        begin
            s <= n;
        end
    end

    assign rif.global_n = s.global_n;
    assign rif.pconf_n = s.pconf_n;
    assign rif.sleep_n = s.sleep_n;
    assign rif.cold_n = s.cold_n;
endmodule
`default_nettype wire

// >>> hdl/lpms_top.sv
// low power mode sequencer: modes, reset sources, registers and data ram
//
// Decided for this implementation: the address map and register access over APB.
`timescale 1ns/1ps
`default_nettype none
module lpms_top
    import lpms_pkg::*;
#(
    parameter int RAM_DEPTH = RAM_BYTES
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [DATA_W-1:0] pwdata,
    output logic [DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic ext_reset_n_pin,
    input wire logic port_a_wake_reset,
    input wire logic wd_expired,
    input wire logic bus_error,
    input wire logic cpu_halt,
    input wire logic irq_req,
    input wire logic event_req,
    output logic rst_cold_n,
    output logic rst_global_n,
    output logic rst_pconf_n,
    output logic rst_sleep_n,
    output logic cpu_run,
    output logic cpu_resume,
    output logic clk_run,
    output logic periph_run,
    output logic rc_en,
    output logic xtal_en,
    output logic ext_clk_en,
    output logic rc_bias,
    output logic [CS_DIV_W-1:0] cpu_div,
    output logic [7:0] rc_trim_first,
    output logic [7:0] rc_trim_second,
    output logic [15:0] cpu_boot_addr,
    output logic [1:0] mode_state,
    output logic irq
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [1:0] rst_sy;
        logic [1:0] pa_sy;
        lpms_mode_t mode;
        logic [7:0] system_control_reg;
        logic [7:0] reset_cause_reg;
        logic [7:0] clock_setup_reg;
        logic [7:0] trim1;
        logic [7:0] trim2;
        logic [IRQ_W-1:0] irq_st;
        logic [IRQ_W-1:0] irq_mask;
        logic [DATA_W-1:0] rdata;
        logic rd_ram;
        logic resume;
    } lpms_core_t;

    localparam lpms_core_t CORE_RST = '{
        rst_sy: '1,
        pa_sy: '0,
        mode: MODE_ACTIVE,
        system_control_reg: '0,
        reset_cause_reg: '0,
        clock_setup_reg: CLK_SETUP_RST,
        trim1: TRIM_RST,
        trim2: TRIM_RST,
        irq_st: '0,
        irq_mask: '0,
        rdata: '0,
        rd_ram: 1'b0,
        resume: 1'b0
    };

    lpms_core_t s_r;
    lpms_core_t s_nxt;

    function automatic logic is_at(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] off);
        return a == off;
    endfunction

    // ------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------
    logic setup;
    logic access;
    logic wr;
    logic hit_ram;
    logic hit_reg;
    logic cold;
    logic pa_wake;
    logic glob_other;
    logic sleep_go;
    logic [DATA_W-1:0] reg_rd;
    logic [7:0] ram_q;

    assign setup = psel && !penable;
    assign access = psel && penable;
    assign wr = access && pwrite;
    assign hit_ram = paddr[RAM_SEL_BIT] && (paddr[1:0] == 2'h0);
    assign hit_reg = is_at(paddr, OFF_SYS_CTRL) || is_at(paddr, OFF_RST_CAUSE)
        || is_at(paddr, OFF_CLK_SETUP) || is_at(paddr, OFF_TRIM1)
        || is_at(paddr, OFF_TRIM2) || is_at(paddr, OFF_MODE)
        || is_at(paddr, OFF_IRQ_ST) || is_at(paddr, OFF_IRQ_MASK);

    // ------------------------------------------------------------
    // reset sources
    // ------------------------------------------------------------
    assign cold = !s_r.rst_sy[1];
    assign pa_wake = s_r.pa_sy[1];
    // in sleep only port A, besides a cold reset, may raise a global reset
    assign glob_other = pa_wake || ((s_r.mode != MODE_SLEEP) &&
        ((wd_expired && s_r.system_control_reg[SC_WD_EN])
        || (bus_error && s_r.system_control_reg[SC_BUSERR_EN])));
    assign sleep_go = wr && is_at(paddr, OFF_RST_CAUSE) && pwdata[RC_SLEEP_REQ]
        && s_r.system_control_reg[SC_SLEEP_ALLOW] && (s_r.mode != MODE_SLEEP);

    // ------------------------------------------------------------
    // register read mux
    // ------------------------------------------------------------
    always_comb
    begin
        reg_rd = '0;
        if (is_at(paddr, OFF_SYS_CTRL))
            reg_rd = DATA_W'(s_r.system_control_reg);
        else if (is_at(paddr, OFF_RST_CAUSE))
            reg_rd = DATA_W'(s_r.reset_cause_reg & RC_MASK);
        else if (is_at(paddr, OFF_CLK_SETUP))
            reg_rd = DATA_W'(s_r.clock_setup_reg);
        else if (is_at(paddr, OFF_TRIM1))
            reg_rd = DATA_W'(s_r.trim1);
        else if (is_at(paddr, OFF_TRIM2))
            reg_rd = DATA_W'(s_r.trim2);
        else if (is_at(paddr, OFF_MODE))
            reg_rd = DATA_W'(s_r.mode);
        else if (is_at(paddr, OFF_IRQ_ST))
            reg_rd = DATA_W'(s_r.irq_st);
        else if (is_at(paddr, OFF_IRQ_MASK))
            reg_rd = DATA_W'(s_r.irq_mask);
    end

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb
    begin
        s_nxt = s_r;
        s_nxt.resume = 1'b0;
        s_nxt.rst_sy = {s_r.rst_sy[0], ext_reset_n_pin};
        s_nxt.pa_sy = {s_r.pa_sy[0], port_a_wake_reset};
        if (setup)
        begin
            s_nxt.rdata = reg_rd;
            s_nxt.rd_ram = hit_ram;
        end
        // software writes
        if (wr && is_at(paddr, OFF_SYS_CTRL))
            s_nxt.system_control_reg = (pwdata[7:0] & SC_MASK)
                | (s_r.system_control_reg & SC_STICKY);
        if (wr && is_at(paddr, OFF_RST_CAUSE))
            s_nxt.reset_cause_reg = s_r.reset_cause_reg & ~(pwdata[7:0] & RC_MASK);
        if (wr && is_at(paddr, OFF_CLK_SETUP))
            s_nxt.clock_setup_reg = pwdata[7:0] & CS_MASK;
        if (wr && is_at(paddr, OFF_TRIM1))
            s_nxt.trim1 = pwdata[7:0];
        if (wr && is_at(paddr, OFF_TRIM2))
            s_nxt.trim2 = pwdata[7:0];
        if (wr && is_at(paddr, OFF_IRQ_MASK))
            s_nxt.irq_mask = pwdata[IRQ_W-1:0];
        if (wr && is_at(paddr, OFF_IRQ_ST))
            s_nxt.irq_st = s_r.irq_st & ~pwdata[IRQ_W-1:0];
        // mode sequencing
        unique case (s_r.mode)
            MODE_ACTIVE:
            begin
                if (sleep_go)
                    s_nxt.mode = MODE_SLEEP;
                else if (cpu_halt)
                    s_nxt.mode = MODE_STANDBY;
            end
            MODE_STANDBY:
            begin
                if (irq_req || event_req)
                begin
                    s_nxt.mode = MODE_ACTIVE;
                    s_nxt.resume = 1'b1;
                    s_nxt.irq_st[IRQ_STBY_WAKE] = 1'b1;
                end
            end
            MODE_SLEEP:
            begin
                s_nxt.mode = MODE_SLEEP;
            end
        endcase
        // flag set wins over a software clear
        if (sleep_go || (s_r.mode == MODE_SLEEP))
            s_nxt.reset_cause_reg[RC_SLEPT] = 1'b1;
        // warm reset: cold-only bits stay, divider and mode return
        if (glob_other)
        begin
            s_nxt.mode = MODE_ACTIVE;
            s_nxt.resume = 1'b0;
            s_nxt.clock_setup_reg[CS_DIV_LO +: CS_DIV_W] = CPU_DIV_RST;
            if (pa_wake)
            begin
                s_nxt.reset_cause_reg[RC_PORTA] = 1'b1;
                s_nxt.irq_st[IRQ_PORTA] = 1'b1;
            end
            if (wd_expired && s_r.system_control_reg[SC_WD_EN])
            begin
                s_nxt.reset_cause_reg[RC_WD] = 1'b1;
                s_nxt.irq_st[IRQ_WD] = 1'b1;
            end
            if (bus_error && s_r.system_control_reg[SC_BUSERR_EN])
            begin
                s_nxt.reset_cause_reg[RC_BUSERR] = 1'b1;
                s_nxt.irq_st[IRQ_BUSERR] = 1'b1;
            end
        end
        if (cold)
        begin
            s_nxt = CORE_RST;
            s_nxt.rst_sy = {s_r.rst_sy[0], ext_reset_n_pin};
            s_nxt.pa_sy = {s_r.pa_sy[0], port_a_wake_reset};
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            s_r <= CORE_RST;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    // ------------------------------------------------------------
    // reset distribution
    // ------------------------------------------------------------
    lpms_rst_if rif ();

    assign rif.cold = cold;
    assign rif.other = glob_other;
    assign rif.pcfg_allow = s_r.system_control_reg[SC_PCFG_ALLOW];
    assign rif.in_sleep = (s_r.mode == MODE_SLEEP);

    lpms_rstgen u_rstgen (
        .pclk(pclk),
        .presetn(presetn),
        .rif(rif)
    );

    // ------------------------------------------------------------
    // data ram
    // ------------------------------------------------------------
    lpms_ram #(.DEPTH(RAM_DEPTH), .AW(RAM_AW)) u_ram (
        .pclk(pclk),
        .we(wr && hit_ram),
        .addr(paddr[RAM_AW+1:2]),
        .wdata(pwdata[7:0]),
        .rdata(ram_q)
    );

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign pready = 1'b1;
    assign pslverr = access && !hit_reg && !hit_ram;
    assign prdata = s_r.rd_ram ? DATA_W'(ram_q) : s_r.rdata;
    assign rst_cold_n = rif.cold_n;
    assign rst_global_n = rif.global_n;
    assign rst_pconf_n = rif.pconf_n;
    assign rst_sleep_n = rif.sleep_n;
    assign cpu_run = (s_r.mode == MODE_ACTIVE) && rif.global_n;
    assign cpu_resume = s_r.resume;
    assign clk_run = (s_r.mode != MODE_SLEEP);
    assign periph_run = (s_r.mode != MODE_SLEEP);
    assign rc_en = s_r.clock_setup_reg[CS_RC_EN] && clk_run;
    assign xtal_en = s_r.clock_setup_reg[CS_XTAL_EN] && clk_run;
    assign ext_clk_en = s_r.clock_setup_reg[CS_EXT_CLK];
    assign rc_bias = s_r.clock_setup_reg[CS_RC_BIAS];
    assign cpu_div = s_r.clock_setup_reg[CS_DIV_LO +: CS_DIV_W];
    assign rc_trim_first = s_r.trim1;
    assign rc_trim_second = s_r.trim2;
    assign cpu_boot_addr = CPU_BOOT_ADDR;
    assign mode_state = s_r.mode;
    assign irq = |(s_r.irq_st & s_r.irq_mask);

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence s_allowed;
        s_r.system_control_reg[SC_SLEEP_ALLOW] && (s_r.mode == MODE_ACTIVE);
    endsequence
    sequence s_request;
        wr && is_at(paddr, OFF_RST_CAUSE) && pwdata[RC_SLEEP_REQ];
    endsequence

    property p_cold_clear;
        cold |=> (s_r.system_control_reg == 8'h00) && rc_en && !xtal_en
            && (s_r.mode == MODE_ACTIVE) && (cpu_boot_addr == CPU_BOOT_ADDR);
    endproperty
    a_cold_clear: assert property (p_cold_clear) else $error("cold reset state wrong");

    property p_warm_keep;
        (glob_other && !cold && !wr) |=> (cpu_div == CPU_DIV_RST)
            && (s_r.system_control_reg == $past(s_r.system_control_reg))
            && (s_r.trim1 == $past(s_r.trim1));
    endproperty
    a_warm_keep: assert property (p_warm_keep) else $error("global reset lost bits");

    property p_halt;
        ((s_r.mode == MODE_ACTIVE) && cpu_halt && !sleep_go && !cold && !glob_other)
            |=> (s_r.mode == MODE_STANDBY) && clk_run && !cpu_run;
    endproperty
    a_halt: assert property (p_halt) else $error("halt did not enter standby");

    property p_wake_stby;
        ((s_r.mode == MODE_STANDBY) && (irq_req || event_req) && !cold && !glob_other)
            |=> (s_r.mode == MODE_ACTIVE) && cpu_resume ##1 !cpu_resume;
    endproperty
    a_wake_stby: assert property (p_wake_stby) else $error("standby wake wrong");

    property p_sleep_entry;
        (s_allowed and s_request) ##0 (!cold && !glob_other) |=> (s_r.mode == MODE_SLEEP);
    endproperty
    a_sleep_entry: assert property (p_sleep_entry) else $error("sleep not entered");

    property p_sleep_stop;
        (s_r.mode == MODE_SLEEP) |-> !clk_run && !periph_run && !cpu_run && !rc_en;
    endproperty
    a_sleep_stop: assert property (p_sleep_stop) else $error("clocks run in sleep");

    property p_sleep_hold;
        ((s_r.mode == MODE_SLEEP) && !cold && !pa_wake) |=> (s_r.mode == MODE_SLEEP);
    endproperty
    a_sleep_hold: assert property (p_sleep_hold) else $error("illegal sleep wake");

    property p_pa_wake;
        ((s_r.mode == MODE_SLEEP) && pa_wake && !cold) |=> (s_r.mode == MODE_ACTIVE)
            && s_r.reset_cause_reg[RC_SLEPT] && s_r.reset_cause_reg[RC_PORTA]
            && (s_r.system_control_reg == $past(s_r.system_control_reg));
    endproperty
    a_pa_wake: assert property (p_pa_wake) else $error("port A wake lost bits");

    property p_flag;
        ((s_r.mode != MODE_SLEEP) ##1 (s_r.mode == MODE_SLEEP))
            |-> s_r.reset_cause_reg[RC_SLEPT];
    endproperty
    a_flag: assert property (p_flag) else $error("slept flag not set");

    property p_req_zero;
        (access && !pwrite && is_at(paddr, OFF_RST_CAUSE)) |-> !prdata[RC_SLEEP_REQ];
    endproperty
    a_req_zero: assert property (p_req_zero) else $error("sleep request read 1");

    property p_glob;
        (cold || glob_other) |=> !rst_global_n && (rst_pconf_n == !($past(cold)
            || $past(s_r.system_control_reg[SC_PCFG_ALLOW])));
    endproperty
    a_glob: assert property (p_glob) else $error("global or pconf reset wrong");

    property p_sleep_rst;
        (s_r.mode == MODE_SLEEP) [*2] |-> !rst_sleep_n;
    endproperty
    a_sleep_rst: assert property (p_sleep_rst) else $error("sleep reset released");
endmodule
`default_nettype wire

// >>> sim/tb_top.sv
// self-checking bench for the low power mode sequencer
`timescale 1ns/1ps
`default_nettype none
module tb_top
    import lpms_pkg::*;
;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [ADDR_W-1:0] paddr = '0;
    logic [DATA_W-1:0] pwdata = '0, prdata, rd;
    logic pready, pslverr, err, ext_reset_n_pin = 1, port_a_wake_reset = 0, wd_expired = 0;
    logic bus_error = 0, cpu_halt = 0, irq_req = 0, event_req = 0, seen;
    logic rst_cold_n, rst_global_n, rst_pconf_n, rst_sleep_n, cpu_run, cpu_resume, clk_run;
    logic periph_run, rc_en, xtal_en, ext_clk_en, rc_bias, irq;
    logic [CS_DIV_W-1:0] cpu_div;
    logic [7:0] rc_trim_first, rc_trim_second;
    logic [15:0] cpu_boot_addr;
    logic [1:0] mode_state;
    int failures = 0, n_tests = 0;
    lpms_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .ext_reset_n_pin(ext_reset_n_pin),
        .port_a_wake_reset(port_a_wake_reset), .wd_expired(wd_expired), .bus_error(bus_error),
        .cpu_halt(cpu_halt), .irq_req(irq_req), .event_req(event_req), .rst_cold_n(rst_cold_n),
        .rst_global_n(rst_global_n), .rst_pconf_n(rst_pconf_n), .rst_sleep_n(rst_sleep_n),
        .cpu_run(cpu_run), .cpu_resume(cpu_resume), .clk_run(clk_run), .periph_run(periph_run),
        .rc_en(rc_en), .xtal_en(xtal_en), .ext_clk_en(ext_clk_en), .rc_bias(rc_bias),
        .cpu_div(cpu_div), .rc_trim_first(rc_trim_first), .rc_trim_second(rc_trim_second),
        .cpu_boot_addr(cpu_boot_addr), .mode_state(mode_state), .irq(irq));
    always #10 pclk = ~pclk;
    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic tally_and_finish();
        $display("tests %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            $display("mismatch at %0t got %h expected %h", $time, got, exp);
            failures++;
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge pclk);
        psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        do
        begin
            @(posedge pclk);
            k++;
        end
        while (pready !== 1'b1 && k < 50);
        rd = prdata;
        err = pslverr;
        psel <= 0; penable <= 0;
        if (k >= 50)
        begin
            chk(0, 1);
            tally_and_finish();
        end
    endtask
    task automatic wait_mode(input logic [1:0] m);
        int k;
        for (k = 0; k < 8 && mode_state !== m; k++)
            @(negedge pclk);
        chk(mode_state, m);
        if (mode_state !== m)
            tally_and_finish();
    endtask
    task automatic pulse_wd(input logic bus);
        int k;
        @(posedge pclk);
        bus_error <= bus;
        wd_expired <= !bus;
        @(posedge pclk);
        bus_error <= 0;
        wd_expired <= 0;
        seen = 0;
        for (k = 0; k < 8 && rst_global_n !== 1'b0; k++)
            @(negedge pclk);
        chk(rst_global_n, 0);
        if (rst_global_n !== 1'b0)
            tally_and_finish();
        for (k = 0; k < 20 && rst_global_n !== 1'b1; k++)
        begin
            if (rst_pconf_n === 1'b0)
                seen = 1;
            @(negedge pclk);
        end
        chk(rst_global_n, 1);
        if (rst_global_n !== 1'b1)
            tally_and_finish();
    endtask
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_cold();
        chk({rc_en, xtal_en, cpu_boot_addr}, {2'b10, CPU_BOOT_ADDR});
        apb(0, OFF_CLK_SETUP, 0);
        chk(rd, 32'h10);
        apb(0, OFF_SYS_CTRL, 0);
        chk(rd, 0);
        apb(0, 12'h7F0, 0);
        chk(err, 1);
        $display("cold start done");
    endtask
    task automatic t_ram();
        apb(1, 12'h800, 32'hA5);
        apb(1, 12'hFFC, 32'h3C);
        apb(0, 12'h800, 0);
        chk(rd, 32'hA5);
        apb(0, 12'hFFC, 0);
        chk(rd, 32'h3C);
        $display("ram done");
    endtask
    task automatic t_standby(input logic ev);
        @(posedge pclk);
        cpu_halt <= 1;
        @(posedge pclk);
        cpu_halt <= 0;
        wait_mode(1);
        chk({cpu_run, clk_run, periph_run}, 3'b011);
        @(posedge pclk);
        if (ev) event_req <= 1; else irq_req <= 1;
        @(posedge pclk);
        event_req <= 0; irq_req <= 0;
        seen = cpu_resume;
        @(negedge pclk);
        seen = seen | cpu_resume;
        wait_mode(0);
        chk({seen, cpu_run}, 2'b11);
        $display("standby done");
    endtask
    task automatic t_sleep();
        apb(1, OFF_IRQ_ST, 32'hF);
        apb(1, OFF_CLK_SETUP, 32'hD3);
        apb(1, OFF_TRIM1, 32'h5A);
        apb(1, OFF_TRIM2, 32'hA5);
        apb(1, OFF_RST_CAUSE, 32'h80);
        repeat (3) @(negedge pclk);
        chk(mode_state, 0);
        apb(0, OFF_RST_CAUSE, 0);
        chk(rd, 0);
        apb(1, OFF_SYS_CTRL, 32'h80);
        apb(1, OFF_RST_CAUSE, 32'h80);
        // harmless access in the slot right after the sleep request
        apb(0, OFF_MODE, 0);
        chk(rd, 2);
        wait_mode(2);
        repeat (2) @(negedge pclk);
        chk({clk_run, periph_run, rst_sleep_n}, 0);
        @(posedge pclk);
        irq_req <= 1;
        cpu_halt <= 1;
        repeat (4) @(negedge pclk);
        chk({mode_state, rst_sleep_n}, 3'b100);
        @(posedge pclk);
        irq_req <= 0;
        cpu_halt <= 0;
        @(posedge pclk);
        port_a_wake_reset <= 1;
        wait_mode(0);
        @(posedge pclk);
        port_a_wake_reset <= 0;
        repeat (8) @(negedge pclk);
        chk({rst_global_n, rst_sleep_n}, 2'b11);
        chk({ext_clk_en, rc_bias, cpu_div}, 5'b11000);
        chk({rc_trim_first, rc_trim_second}, 16'h5AA5);
        apb(0, OFF_SYS_CTRL, 0);
        chk(rd, 32'h80);
        apb(0, OFF_RST_CAUSE, 0);
        chk(rd, 32'h48);
        apb(1, OFF_RST_CAUSE, 32'h40);
        apb(0, OFF_RST_CAUSE, 0);
        chk(rd, 32'h08);
        apb(0, OFF_IRQ_ST, 0);
        chk(rd[1], 1);
        chk(irq, 0);
        apb(1, OFF_IRQ_MASK, 32'h2);
        @(negedge pclk);
        chk(irq, 1);
        apb(1, OFF_IRQ_ST, 32'h2);
        @(negedge pclk);
        chk(irq, 0);
        $display("sleep done");
    endtask
    task automatic t_global();
        apb(1, OFF_SYS_CTRL, 32'h30);
        pulse_wd(0);
        chk(seen, 0);
        apb(1, OFF_SYS_CTRL, 32'h70);
        apb(1, OFF_CLK_SETUP, 32'hD3);
        pulse_wd(1);
        chk(seen, 1);
        chk({ext_clk_en, rc_bias, rc_en, cpu_div}, 6'b111000);
        chk(rc_trim_first, 8'h5A);
        apb(0, OFF_RST_CAUSE, 0);
        chk(rd, 32'h38);
        $display("global reset done");
    endtask
    task automatic t_pin();
        int k;
        @(posedge pclk);
        ext_reset_n_pin <= 0;
        repeat (5) @(posedge pclk);
        @(negedge pclk);
        chk({rst_cold_n, rst_global_n, rst_pconf_n, rst_sleep_n}, 0);
        chk({rc_en, xtal_en, mode_state}, 4'b1000);
        @(posedge pclk);
        ext_reset_n_pin <= 1;
        for (k = 0; k < 8 && rst_cold_n !== 1'b1; k++)
            @(negedge pclk);
        chk(rst_cold_n, 1);
        if (rst_cold_n !== 1'b1)
            tally_and_finish();
        apb(0, OFF_SYS_CTRL, 0);
        chk(rd, 0);
        apb(0, OFF_RST_CAUSE, 0);
        chk(rd, 0);
        apb(0, OFF_TRIM1, 0);
        chk(rd, 0);
        apb(0, OFF_CLK_SETUP, 0);
        chk(rd, 32'h10);
        apb(0, 12'h800, 0);
        chk(rd, 32'hA5);
        $display("pin reset done");
    endtask
    initial
    begin
        repeat (16) @(posedge pclk);
        presetn <= 1;
        for (int k = 0; k < 20 && rst_cold_n !== 1'b1; k++)
            @(negedge pclk);
        chk({rst_cold_n, rst_global_n, cpu_run, mode_state}, 5'b11100);
        if (rst_cold_n !== 1'b1)
            tally_and_finish();
        t_cold();
        t_ram();
        t_standby(0);
        t_standby(1);
        t_sleep();
        t_global();
        t_pin();
        tally_and_finish();
    end
endmodule
`default_nettype wire
